// ==== logic/laser_psu_consts.svh ====
// constants for the laser supply serial command block
`ifndef LASER_PSU_CONSTS_SVH
`define LASER_PSU_CONSTS_SVH

`define CLK_HZ        100000000
`define BAUD_RATE     19200
`define BIT_CYCLES    (`CLK_HZ / `BAUD_RATE)
`define TICK_SECONDS  1
`define SEC_CYCLES    (`CLK_HZ * `TICK_SECONDS)

`define REG_STATUS    8'h00
`define REG_CTRL      8'h04
`define REG_SETPT     8'h08
`define CTRL_OFF_BIT  0

`define RST_CURRENT   7'h00
`define RST_POWER_MW  16'h0000
`define RST_ST_EN     1'b0
`define MAX_PCT       7'h64
`define REDUCED_PCT   7'h32

`define CH_CR         8'h0d
`define CH_LF         8'h0a
`define CH_EQ         8'h3d
`define CH_QM         8'h3f
`define CH_ZERO       8'h30
`define CH_NINE       8'h39
`define CH_COMMA      8'h2c
`define CRLF          16'h0d0a

`define CMD_OFF       64'h0000_0000_004f_4646
`define CMD_ON        64'h0000_0000_0000_4f4e
`define CMD_CONTROL   64'h0043_4f4e_5452_4f4c
`define CMD_CURRENT   64'h0043_5552_5245_4e54
`define CMD_POWER     64'h0000_0050_4f57_4552
`define CMD_START_EN  64'h0000_0000_5354_454e
`define CMD_START_LVL 64'h0000_0053_5450_4f57
`define CMD_CALIBRATE 64'h0000_0000_4143_5450
`define CMD_WRITE     64'h0000_0057_5249_5445
`define CMD_HEAD_TEMP 64'h004c_4153_5445_4d50
`define CMD_SUP_TEMP  64'h0050_5355_5445_4d50
`define CMD_STATUS    64'h0000_5354_4154_5553
`define CMD_TIMERS    64'h0000_5449_4d45_5253
`define ARG_YES       64'h0000_0000_0059_4553
`define ARG_NO        64'h0000_0000_0000_4e4f

`define TXT_CLOSED    48'h434c_4f53_4544
`define TXT_OPEN      32'h4f50_454e
`define TXT_TIME      40'h54_494d_453d

`endif

// ==== logic/laser_psu_pkg.sv ====
// types shared by the laser supply serial command block
package laser_psu_pkg;
  typedef enum logic [1:0] {
    S_KEY_OFF = 2'b00,
    S_READY   = 2'b01,
    S_SER_OFF = 2'b10,
    S_EMIT    = 2'b11
  } emission_state_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;
  typedef enum logic {
    MODE_CURRENT = 1'b0,
    MODE_POWER   = 1'b1
  } reg_mode_t;
  typedef struct packed {
    logic [15:0] cal;
    logic        st_en;
    logic [15:0] st_pow;
  } nv_record_t;
  typedef struct packed {
    logic        emission;
    reg_mode_t   mode;
    logic [6:0]  current_pct;
    logic [15:0] power_mw;
  } drive_t;
endpackage

// ==== logic/laser_psu_serial_command_control.sv ====
// serial command interpreter and emission gating for a laser supply
// Operation
// - open safety loop stops emission until press or on command with switch closed
// - serial enable needs loop and switch closed
// - power mode, full current need strap
// - link is 19200 baud, 8N1, no flow
// - every reply ends with CR then LF
// - off command stops emission unconditionally
// - on command obeys loop and switch
// - control command selects current or power mode
// - current command sets percent of maximum
// - power command sets milliwatt target
// - power query returns monitor photodiode power
// - start-up enable default, kept after store
// - start-up power default, kept after store
// - calibrate command matches measured to given
// - store saves calibration and start-up defaults
// - temperature queries return head and supply
// - status query returns safety loop state
// - timers query returns labelled run times
// - serial disable reported as own state
`timescale 1ns/1ps
`include "laser_psu_consts.svh"

module laser_psu_serial_command_control
  import laser_psu_pkg::*;
#(
  parameter int BIT_CYCLES = `BIT_CYCLES,
  parameter int SEC_CYCLES = `SEC_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        interlock_closed,
  input  wire logic        key_on,
  input  wire logic        enable_switch,
  input  wire logic        current_strap,
  input  wire logic [15:0] measured_mw,
  input  wire logic [15:0] head_temp,
  input  wire logic [15:0] supply_temp,
  input  wire logic        nv_load,
  input  wire nv_record_t  nv_in,
  output logic             nv_store,
  output nv_record_t       nv_out,
  output drive_t           drive,
  output emission_state_t  panel_state,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);

  localparam logic [12:0] FULL = 13'(BIT_CYCLES - 1);
  localparam logic [12:0] HALF = 13'(BIT_CYCLES / 2 - 1);
  localparam logic [26:0] SEC  = 27'(SEC_CYCLES - 1);

  rx_state_t       rx_st;
  logic [12:0]     rx_cnt;
  logic [2:0]      rx_bit;
  logic [7:0]      rx_sh;
  logic            rx_valid;
  logic [12:0]     tx_cnt;
  logic [3:0]      tx_bits;
  logic [8:0]      tx_sh;
  logic [159:0]    reply;
  logic [4:0]      reply_left;
  logic [63:0]     name;
  logic [63:0]     arg;
  logic [15:0]     num;
  logic            in_arg;
  logic            query;
  emission_state_t state;
  reg_mode_t       mode;
  logic [6:0]      current_pct;
  logic [15:0]     power_sp;
  logic [15:0]     cal;
  logic            st_en;
  logic [15:0]     st_pow;
  logic            en_q;
  logic            boot;
  logic            host_off;
  logic [26:0]     sec_cnt;
  logic [15:0]     head_time;
  logic [15:0]     supply_time;

  logic        tx_load;
  logic        busy;
  logic        exec;
  logic        plain;
  logic        loop_ok;
  logic        press;
  logic [15:0] meas_cal;
  logic [6:0]  next_pct;
  logic        c_off, c_on, c_ctl_cur, c_ctl_pow, c_cur, c_pow, c_powq;
  logic        c_startup_enable_default_cmd, c_startup_level_default_cmd, c_measured_output_calibrate_cmd, c_write, c_htemp, c_stemp;
  logic        c_stat, c_tim;

  function automatic logic [39:0] dec5(input logic [15:0] v);
    logic [19:0] b;
    logic [15:0] s;
    logic [39:0] r;
    b = '0;
    s = v;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 5; k++) begin
        if (b[4*k +: 4] > 4'h4) begin
          b[4*k +: 4] = b[4*k +: 4] + 4'h3;
        end
      end
      b = {b[18:0], s[15]};
      s = {s[14:0], 1'b0};
    end
    for (int k = 0; k < 5; k++) begin
      r[8*k +: 8] = {4'h3, b[4*k +: 4]};
    end
    return r;
  endfunction

  assign loop_ok  = interlock_closed & key_on;
  assign press    = enable_switch & ~en_q;
  assign tx_load  = (tx_bits == 4'h0) && (reply_left != 5'h00);
  assign busy     = (reply_left != 5'h00) || (tx_bits != 4'h0);
  // host waits
  // a line finishing while a reply drains is dropped, not queued
  assign exec     = rx_valid && (rx_sh == `CH_CR) && !busy;
  assign plain    = !in_arg && !query;
  assign meas_cal = measured_mw + cal;

  assign c_off     = exec && plain && name == `CMD_OFF;
  assign c_on      = exec && plain && name == `CMD_ON;
  assign c_ctl_cur = exec && in_arg && name == `CMD_CONTROL
                     && arg == `CMD_CURRENT;
  assign c_ctl_pow = exec && in_arg && name == `CMD_CONTROL
                     && arg == `CMD_POWER;
  assign c_cur     = exec && in_arg && name == `CMD_CURRENT;
  assign c_pow     = exec && in_arg && name == `CMD_POWER;
  assign c_powq    = exec && query && name == `CMD_POWER;
  assign c_startup_enable_default_cmd    = exec && in_arg && name == `CMD_START_EN;
  assign c_startup_level_default_cmd   = exec && in_arg && name == `CMD_START_LVL;
  assign c_measured_output_calibrate_cmd    = exec && in_arg && name == `CMD_CALIBRATE;
  assign c_write   = exec && plain && name == `CMD_WRITE;
  assign c_htemp   = exec && query && name == `CMD_HEAD_TEMP;
  assign c_stemp   = exec && query && name == `CMD_SUP_TEMP;
  assign c_stat    = exec && query && name == `CMD_STATUS;
  assign c_tim     = exec && query && name == `CMD_TIMERS;

  assign next_pct = (current_strap || current_pct <= `REDUCED_PCT)
                    ? current_pct : `REDUCED_PCT;

  // receiver
  // rxd is sampled mid bit; a false start is dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st    <= RX_IDLE;
      rx_cnt   <= '0;
      rx_bit   <= '0;
      rx_sh    <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (rx_cnt != 13'h0000) begin
        rx_cnt <= rx_cnt - 13'h0001;
      end else begin
        case (rx_st)
          RX_IDLE: if (!rxd) begin
            rx_st  <= RX_START;
            rx_cnt <= HALF;
          end
          RX_START: begin
            rx_st  <= rxd ? RX_IDLE : RX_DATA;
            rx_cnt <= FULL;
            rx_bit <= '0;
          end
          RX_DATA: begin
            rx_sh  <= {rxd, rx_sh[7:1]};
            rx_cnt <= FULL;
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_st <= RX_STOP;
            end
          end
          RX_STOP: begin
            rx_st    <= RX_IDLE;
            rx_valid <= rxd;
          end
          default: rx_st <= RX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txd     <= 1'b1;
      tx_cnt  <= '0;
      tx_bits <= '0;
      tx_sh   <= '1;
    end else if (tx_load) begin
      txd     <= 1'b0;
      tx_sh   <= {1'b1, reply[159:152]};
      tx_bits <= 4'ha;
      tx_cnt  <= FULL;
    end else if (tx_bits != 4'h0) begin
      if (tx_cnt != 13'h0000) begin
        tx_cnt <= tx_cnt - 13'h0001;
      end else begin
        tx_bits <= tx_bits - 4'h1;
        if (tx_bits != 4'h1) begin
          txd    <= tx_sh[0];
          tx_sh  <= {1'b1, tx_sh[8:1]};
          tx_cnt <= FULL;
        end
      end
    end
  end

  // line assembly
  // names longer than eight characters keep only their tail
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      name   <= '0;
      arg    <= '0;
      num    <= '0;
      in_arg <= 1'b0;
      query  <= 1'b0;
    end else if (rx_valid) begin
      if (rx_sh == `CH_CR) begin
        name   <= '0;
        arg    <= '0;
        num    <= '0;
        in_arg <= 1'b0;
        query  <= 1'b0;
      end else if (rx_sh == `CH_LF) begin
        in_arg <= in_arg;
      end else if (rx_sh == `CH_EQ) begin
        in_arg <= 1'b1;
      end else if (rx_sh == `CH_QM) begin
        query <= 1'b1;
      end else if (in_arg) begin
        arg <= {arg[55:0], rx_sh};
        if (rx_sh >= `CH_ZERO && rx_sh <= `CH_NINE) begin
          num <= 16'({num, 3'b000} + {num, 1'b0} + rx_sh[3:0]);
        end
      end else begin
        name <= {name[55:0], rx_sh};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reply      <= '0;
      reply_left <= '0;
    end else if (exec) begin
      if (c_powq) begin
        reply      <= {dec5(meas_cal), `CRLF, 104'h0};
        reply_left <= 5'h07;
      end else if (c_htemp || c_stemp) begin
        reply      <= {dec5(c_htemp ? head_temp : supply_temp),
                       `CRLF, 104'h0};
        reply_left <= 5'h07;
      end else if (c_stat && loop_ok) begin
        reply      <= {`TXT_CLOSED, `CRLF, 96'h0};
        reply_left <= 5'h08;
      end else if (c_stat) begin
        reply      <= {`TXT_OPEN, `CRLF, 112'h0};
        reply_left <= 5'h06;
      end else if (c_tim) begin
        reply      <= {`TXT_TIME, dec5(head_time), `CH_COMMA,
                       dec5(supply_time), `CRLF, 16'h0};
        reply_left <= 5'h12;
      end else begin
        reply      <= {`CRLF, 144'h0};
        reply_left <= 5'h02;
      end
    end else if (tx_load) begin
      reply      <= {reply[151:0], 8'h00};
      reply_left <= reply_left - 5'h01;
    end
  end

  // settings and calibration
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode        <= MODE_CURRENT;
      current_pct <= `RST_CURRENT;
      power_sp    <= `RST_POWER_MW;
      cal         <= '0;
      st_en       <= `RST_ST_EN;
      st_pow      <= `RST_POWER_MW;
      nv_store    <= 1'b0;
      nv_out      <= '0;
    end else begin
      nv_store <= c_write;
      if (nv_load) begin
        cal      <= nv_in.cal;
        st_en    <= nv_in.st_en;
        st_pow   <= nv_in.st_pow;
        power_sp <= nv_in.st_pow;
      end
      if (c_ctl_cur) mode <= MODE_CURRENT;
      if (c_ctl_pow) mode <= MODE_POWER;
      if (c_cur) begin
        current_pct <= (num > 16'(`MAX_PCT)) ? `MAX_PCT : num[6:0];
      end
      if (c_pow) power_sp <= num;
      if (c_startup_enable_default_cmd && arg == `ARG_YES) st_en <= 1'b1;
      if (c_startup_enable_default_cmd && arg == `ARG_NO) st_en <= 1'b0;
      if (c_startup_level_default_cmd) st_pow <= num;
      if (c_measured_output_calibrate_cmd) cal <= num - measured_mw;
      if (c_write) nv_out <= '{cal: cal, st_en: st_en, st_pow: st_pow};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_KEY_OFF;
      en_q  <= 1'b0;
      boot  <= 1'b1;
    end else begin
      en_q <= enable_switch;
      if (state == S_READY) boot <= 1'b0;
      if (!loop_ok) begin
        state <= S_KEY_OFF;
      end else begin
        case (state)
          S_KEY_OFF: state <= S_READY;
          S_READY, S_SER_OFF: begin
            if (c_off || host_off) begin
              state <= S_SER_OFF;
            end else if (press || (c_on && enable_switch)
                         || (boot && st_en && state == S_READY)) begin
              state <= S_EMIT;
            end
          end
          S_EMIT: if (c_off || host_off) state <= S_SER_OFF;
          default: state <= S_KEY_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      panel_state <= S_KEY_OFF;
      drive       <= '0;
    end else begin
      panel_state       <= state;
      drive.emission    <= state == S_EMIT;
      drive.mode        <= current_strap ? mode : MODE_CURRENT;
      drive.current_pct <= next_pct;
      drive.power_mw    <= power_sp;
    end
  end

  // run timers count whole seconds, wrapping at 16 bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt     <= '0;
      head_time   <= '0;
      supply_time <= '0;
    end else if (sec_cnt == SEC) begin
      sec_cnt     <= '0;
      supply_time <= supply_time + 16'h0001;
      if (state == S_EMIT) head_time <= head_time + 16'h0001;
    end else begin
      sec_cnt <= sec_cnt + 27'h000_0001;
    end
  end

  // register port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata    <= '0;
      host_off <= 1'b0;
    end else begin
      host_off <= wr && addr == `REG_CTRL && wdata[`CTRL_OFF_BIT];
      rdata    <= '0;
      if (rd && addr == `REG_STATUS) begin
        rdata <= {27'h0, loop_ok, current_strap, mode, state};
      end else if (rd && addr == `REG_SETPT) begin
        rdata <= {power_sp, 9'h000, current_pct};
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  loop_off_a: assert property (
    !loop_ok |=> state == S_KEY_OFF ##1 !drive.emission)
    else $error("emission not stopped by open loop");
  serial_gate_a: assert property (
    c_on && !enable_switch && state != S_EMIT && !press
    |=> state != S_EMIT)
    else $error("serial enable without enable switch");
  strap_gate_a: assert property (
    !current_strap |=> drive.mode == MODE_CURRENT
                       && drive.current_pct <= `REDUCED_PCT)
    else $error("full power without strap");
  reply_end_a: assert property (
    tx_load && reply_left == 5'h02 |-> reply[159:152] == `CH_CR)
    else $error("reply not ended by CR");
  reply_lf_a: assert property (
    tx_load && reply_left == 5'h01 |-> reply[159:152] == `CH_LF)
    else $error("reply not ended by LF");
  off_cmd_a: assert property (
    c_off |=> state != S_EMIT ##1 !drive.emission)
    else $error("off command ignored");
  mode_sel_a: assert property (
    c_ctl_pow |=> mode == MODE_POWER)
    else $error("power mode not selected");
  current_set_a: assert property (
    c_cur && num <= 16'h0064 |=> {9'h000, current_pct} == $past(num))
    else $error("current percent not taken");
  power_set_a: assert property (
    c_pow && !nv_load |=> power_sp == $past(num))
    else $error("power target not taken");
  calib_a: assert property (
    c_measured_output_calibrate_cmd && $stable(measured_mw) [*1] ##1 $stable(measured_mw)
    |-> meas_cal == $past(num))
    else $error("calibration does not match value");
  store_rec_a: assert property (
    c_write |=> nv_store && nv_out.cal == $past(cal)
                && nv_out.st_pow == $past(st_pow))
    else $error("store record wrong");
  ser_state_a: assert property (
    state == S_EMIT && loop_ok && c_off |=> ##1 panel_state == S_SER_OFF)
    else $error("serial disable not reported");

  emit_cov_c:   cover property (state == S_READY ##1 state == S_EMIT);
  ser_off_c:    cover property (state == S_EMIT ##1 state == S_SER_OFF);
  timers_cov_c: cover property (c_tim);

endmodule

// ==== sim/host_term.sv ====
// host terminal model on the far side of the serial link
`timescale 1ns/1ps
module host_term #(
  parameter int BIT_CYCLES = 10
) (
  input  wire logic    ref_clk,
  input  wire logic    txd,
  output logic         rxd,
  output logic [127:0] reply,
  output logic         reply_done,
  output logic         crlf_ok
);
  logic [135:0] line;
  logic [7:0]   b;
  int           n_replies;
  initial begin
    rxd = 1'b1;
    reply = '0;
    reply_done = 1'b0;
    crlf_ok = 1'b0;
    line = '0;
    n_replies = 0;
  end
  // 8N1 frame, lsb first, no flow
  task automatic send_byte(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      rxd <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge ref_clk);
    end
  endtask
  task automatic send_line(input logic [127:0] s);
    int n0;
    n0 = n_replies;
    // zero bytes are left padding, not characters
    for (int i = 15; i >= 0; i--)
      if (s[8*i +: 8] != 8'h00) send_byte(s[8*i +: 8]);
    send_byte(8'h0d);
    for (int k = 0; k < 400 * BIT_CYCLES && n_replies == n0; k++)
      @(posedge ref_clk);
  endtask
  // reply framed by CR then LF
  initial forever begin
    @(negedge txd);
    repeat (BIT_CYCLES / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge ref_clk);
      b[i] = txd;
    end
    repeat (BIT_CYCLES) @(posedge ref_clk);
    if (txd === 1'b1 && b == 8'h0a) begin
      crlf_ok <= (line[7:0] == 8'h0d);
      reply <= line[135:8];
      line = '0;
      reply_done <= 1'b1;
      @(posedge ref_clk);
      reply_done <= 1'b0;
      n_replies++;
    end else if (txd === 1'b1) begin
      line = {line[127:0], b};
    end
  end
endmodule

// ==== sim/tb_laser_psu_serial_command_control.sv ====
// self-checking bench for the serial command block
`timescale 1ns/1ps
`include "laser_psu_consts.svh"
module tb_laser_psu_serial_command_control
  import laser_psu_pkg::*;
  ;
  typedef struct packed {
    logic [127:0] v;
    logic [127:0] m;
  } note_t;
  logic            ref_clk, rst_n, rxd, txd, nv_load, nv_store;
  logic            interlock_closed, key_on, enable_switch, current_strap;
  logic [15:0]     measured_mw, head_temp, supply_temp, v, cal;
  nv_record_t      nv_in, nv_out, nv_exp;
  drive_t          drive;
  emission_state_t panel_state;
  logic [7:0]      addr;
  logic [31:0]     wdata, rdata, lfsr;
  logic            wr, rd, rd_d, reply_done, crlf_ok;
  logic [127:0]    reply;
  note_t           nt;
  note_t           rq[$];
  logic [31:0]     bq[$];
  int              n_errors, checks_done, nv_seen;

  laser_psu_serial_command_control #(.BIT_CYCLES(10), .SEC_CYCLES(50))
    laser_psu_serial_command_control_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .rxd(rxd), .txd(txd),
    .interlock_closed(interlock_closed), .key_on(key_on),
    .enable_switch(enable_switch), .current_strap(current_strap),
    .measured_mw(measured_mw), .head_temp(head_temp),
    .supply_temp(supply_temp), .nv_load(nv_load), .nv_in(nv_in),
    .nv_store(nv_store), .nv_out(nv_out), .drive(drive),
    .panel_state(panel_state), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  host_term #(.BIT_CYCLES(10)) host_term_inst (
    .ref_clk(ref_clk), .txd(txd), .rxd(rxd), .reply(reply),
    .reply_done(reply_done), .crlf_ok(crlf_ok));

  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [39:0] dec5(input logic [15:0] x);
    logic [39:0] r;
    int t;
    t = x;
    for (int i = 0; i < 5; i++) begin
      r[i*8 +: 8] = 8'h30 + 8'(t % 10);
      t = t / 10;
    end
    return r;
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [127:0] s, input logic [127:0] e);
    rq.push_back('{e, '1});
    host_term_inst.send_line(s);
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    bq.push_back(e);
    @(posedge ref_clk);
    rd <= 1'b0;
  endtask

  // replies and read data are compared against the oldest note
  always @(posedge ref_clk) begin
    rd_d <= rd;
    if (reply_done) begin
      if (rq.size() == 0) check(1, 0);
      else begin
        nt = rq.pop_front();
        check(reply & nt.m, nt.v);
        check(crlf_ok, 1);
      end
    end
    if (rd_d) check(rdata, bq.pop_front());
    else if (rst_n && rdata !== 32'h0) check(rdata, 0);
    if (nv_store) begin
      nv_seen++;
      check(nv_out, nv_exp);
    end
  end

  initial begin
    #1_000_000;
    n_errors++;
    end_sim();
  end

  initial begin
    {ref_clk, rst_n, nv_load, wr, rd, rd_d} = '0;
    {interlock_closed, key_on, enable_switch, current_strap} = '0;
    {addr, wdata, nv_in, nv_exp} = '0;
    n_errors = 0;
    checks_done = 0;
    nv_seen = 0;
    lfsr = 32'h0000_8f3c;
    lfsr = next_rand(lfsr);
    measured_mw = {6'h00, lfsr[9:0]};
    head_temp = {8'h00, lfsr[17:10]};
    supply_temp = {8'h00, lfsr[25:18]};
    wait_c(20);
    check(drive, 0);
    check({txd, nv_store, panel_state}, 4'h8);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    {interlock_closed, key_on, current_strap} <= 3'b111;
    wait_c(4);
    check(panel_state, S_READY);
    cmd("ON", 0);
    check({drive.emission, panel_state}, {1'b0, S_READY});
    @(posedge ref_clk);
    enable_switch <= 1'b1;
    wait_c(4);
    check({drive.emission, panel_state}, {1'b1, S_EMIT});
    cmd("OFF", 0);
    check({drive.emission, panel_state}, {1'b0, S_SER_OFF});
    cmd("ON", 0);
    check(panel_state, S_EMIT);
    @(posedge ref_clk);
    interlock_closed <= 1'b0;
    wait_c(3);
    check({drive.emission, panel_state}, {1'b0, S_KEY_OFF});
    cmd("STATUS?", `TXT_OPEN);
    @(posedge ref_clk);
    interlock_closed <= 1'b1;
    wait_c(4);
    check(panel_state, S_READY);
    @(posedge ref_clk);
    enable_switch <= 1'b0;
    wait_c(2);
    @(posedge ref_clk);
    enable_switch <= 1'b1;
    wait_c(4);
    check(panel_state, S_EMIT);
    cmd("CONTROL=POWER", 0);
    check(drive.mode, MODE_POWER);
    cmd("CONTROL=CURRENT", 0);
    check(drive.mode, MODE_CURRENT);
    cmd("CURRENT=150", 0);
    check(drive.current_pct, `MAX_PCT);
    current_strap <= 1'b0;
    cmd("CURRENT=85", 0);
    check(drive.current_pct, `REDUCED_PCT);
    cmd("CONTROL=POWER", 0);
    check(drive.mode, MODE_CURRENT);
    current_strap <= 1'b1;
    cmd("CURRENT=42", 0);
    check(drive.current_pct, 7'h2a);
    lfsr = next_rand(lfsr);
    v = 16'(lfsr[13:0] % 10000);
    cmd({"POWER=", dec5(v)}, 0);
    check(drive.power_mw, v);
    bus_rd(`REG_SETPT, {v, 9'h000, 7'h2a});
    cmd("POWER?", dec5(measured_mw));
    cal = v - measured_mw;
    cmd({`CMD_CALIBRATE, "=", dec5(v)}, 0);
    cmd("POWER?", dec5(v));
    cmd({`CMD_HEAD_TEMP, "?"}, dec5(head_temp));
    cmd({`CMD_SUP_TEMP, "?"}, dec5(supply_temp));
    cmd("STATUS?", `TXT_CLOSED);
    rq.push_back('{{`TXT_TIME, 40'h0, `CH_COMMA, 40'h0},
                   {40'hff_ffff_ffff, 40'h0, 8'hff, 40'h0}});
    host_term_inst.send_line("TIMERS?");
    for (int i = 0; i < 2; i++) begin
      nv_exp = '{cal, i == 0, 16'h04d2};
      cmd(i == 0 ? {`CMD_START_EN, "=YES"} : {`CMD_START_EN, "=NO"},
          0);
      cmd({`CMD_START_LVL, "=1234"}, 0);
      cmd("WRITE", 0);
      check(nv_seen, i + 1);
    end
    cmd("BOGUS", 0);
    bus_rd(`REG_STATUS, {27'h0, 2'b11, MODE_POWER, S_EMIT});
    bus_rd(8'h0c, 32'h0000_0000);
    bus_wr(`REG_CTRL, 32'h0000_0001);
    wait_c(3);
    check(panel_state, S_SER_OFF);
    bus_rd(`REG_CTRL, 32'h0000_0000);
    @(posedge ref_clk);
    nv_in <= '{16'h0000, 1'b0, 16'h0309};
    nv_load <= 1'b1;
    @(posedge ref_clk);
    nv_load <= 1'b0;
    wait_c(3);
    check(drive.power_mw, 16'h0309);
    // a reply or read that never came leaves its note behind
    check(rq.size() + bq.size(), 0);
    end_sim();
  end
endmodule
